//--- pkg/sld_pkg.sv
// Package for the serial LED segment driver: frame layout and timing counts.
// Assumes core_clk at 40 MHz; the serial clock arrives asynchronously.
package sld_pkg;

  // ----------------------------------------
  // Frame layout
  // ----------------------------------------
  localparam int SLD_DATA_BITS = 35;
  localparam int SLD_FRAME_CLOCKS = 36;
  localparam int SLD_CNT_W = 6;
  localparam logic [5:0] SLD_CNT_RESET = 6'h00;
  localparam logic [34:0] SLD_LATCH_RESET = 35'h0;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int SLD_CORE_CLK_HZ = 40000000;
  localparam int SLD_SCLK_MAX_HZ = 500000;
  // Core cycles in the shortest serial-clock period
  localparam int SLD_SCLK_MIN_CYC = SLD_CORE_CLK_HZ / SLD_SCLK_MAX_HZ;

  // ----------------------------------------
  // Receiver states
  // ----------------------------------------
  typedef enum logic [2:0] {
    SLD_IDLE = 3'b001,
    SLD_SHIFT = 3'b010,
    SLD_CLEAR = 3'b100
  } sld_state_t;

endpackage : sld_pkg

//--- hdl/sld_fifo.sv
// Small synchronous FIFO carrying completed frames to the output latches.
// Assumes one clock and synchronous active-low reset.
`timescale 1ns/100ps
module sld_fifo #(
  parameter int WIDTH = 35,
  parameter int DEPTH = 8
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pop;

  assign in_ready = (count_reg != (AW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_reg[rd_ptr_reg];

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  // ----------------------------------------
  // Pointers
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

endmodule : sld_fifo

//--- hdl/sld_driver.sv
// Serial LED segment driver: frame receiver, transfer FIFO and output latches.
// Assumes serial clock, data and enable pins are asynchronous to core_clk.
//
// Summary of operation
// - Frames arrive on serial data plus clock only; no load strobe exists.
// - On 36th clock high phase, transfer all 35 shifted bits to latches.
// - In following clock low phase, clear all shift stages.
// - Clear spares first stage master so a following start bit is caught.
// - Reset clears every shift stage and every output latch.
// - After reset, a start bit with first clock resumes reception.
// - First data bit after start drives output bit 1, onward in order.
// - Latched one turns its output on; zero leaves it off.
// - Outputs hold between transfers; change only where new bit differs.
// - Reduced variant loses output 35, using that position as data enable.
// - Shift chain is static; clock may stop indefinitely between edges.
`timescale 1ns/100ps
module sld_driver
  import sld_pkg::*;
#(
  parameter int DATA_BITS = SLD_DATA_BITS,
  parameter int FIFO_DEPTH = 8,
  parameter bit REDUCED = 1'b0
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ser_clk,
  input wire logic ser_data,
  input wire logic data_enable,
  output logic [DATA_BITS-1:0] seg_on,
  output logic frame_stall
);

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;
  logic clk_prev_reg;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sync1_reg <= 3'h0;
      sync2_reg <= 3'h0;
      clk_prev_reg <= 1'b0;
    end else begin
      sync1_reg <= {data_enable, ser_data, ser_clk};
      sync2_reg <= sync1_reg;
      clk_prev_reg <= sync2_reg[0];
    end
  end

  logic s_clk;
  logic s_data;
  logic s_en;
  logic clk_rise;
  logic clk_fall;
  logic gate_ok;

  assign s_clk = sync2_reg[0];
  assign s_data = sync2_reg[1];
  assign s_en = sync2_reg[2];
  // Full variant ignores the enable pin and is always listening
  assign gate_ok = REDUCED ? s_en : 1'b1;
  assign clk_rise = s_clk && !clk_prev_reg && gate_ok;
  assign clk_fall = !s_clk && clk_prev_reg && gate_ok;

  // ----------------------------------------
  // Frame receiver
  // ----------------------------------------
  // Shift state is held in flops; nothing times out, so a stopped clock
  // simply freezes the frame in place.
  sld_state_t state_reg;
  logic [SLD_CNT_W-1:0] count_reg;
  logic [DATA_BITS-1:0] shift_reg;
  logic [DATA_BITS-1:0] frm_in;
  logic in_idle;
  logic in_shift;
  logic in_clear;
  logic start_seen;
  logic last_clock;
  logic chain_shift;
  logic chain_clear;
  logic load_pulse;
  logic fifo_ready;

  assign in_idle = (state_reg == SLD_IDLE);
  assign in_shift = (state_reg == SLD_SHIFT);
  assign in_clear = (state_reg == SLD_CLEAR);
  // Start bit of one opens a frame; zeros are idle clocks
  assign start_seen = clk_rise && s_data && (in_idle || in_clear);
  assign last_clock = (count_reg == SLD_CNT_W'(SLD_FRAME_CLOCKS - 1));
  assign chain_shift = clk_rise && in_shift;
  // Clear waits for the low phase, or for a rise that comes first
  assign chain_clear = in_clear && (clk_fall || clk_rise);

  // Transfer on the 36th rise; stalls only if the FIFO is full
  assign load_pulse = chain_shift && last_clock && fifo_ready;
  assign frame_stall = !fifo_ready;

  // Last data bit rides the very rise that transfers the frame,
  // so it joins the word here rather than a cycle later
  always_comb begin
    frm_in = shift_reg;
    if (chain_shift && last_clock) begin
      frm_in[DATA_BITS-1] = s_data;
    end
  end

  // ----------------------------------------
  // Frame state
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_reg <= SLD_IDLE;
    end else begin
      case (state_reg)
        SLD_IDLE: begin
          if (start_seen) begin
            state_reg <= SLD_SHIFT;
          end
        end
        SLD_SHIFT: begin
          // A full FIFO parks the frame at its last clock
          if (load_pulse) begin
            state_reg <= SLD_CLEAR;
          end
        end
        SLD_CLEAR: begin
          if (clk_rise) begin
            state_reg <= s_data ? SLD_SHIFT : SLD_IDLE;
          end else if (clk_fall) begin
            state_reg <= SLD_IDLE;
          end
        end
        default: begin
          state_reg <= SLD_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Clock count
  // ----------------------------------------
  // One after the start bit, 35 on the last data bit
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      count_reg <= SLD_CNT_RESET;
    end else if (start_seen) begin
      count_reg <= SLD_CNT_W'(1);
    end else if (chain_clear) begin
      count_reg <= SLD_CNT_RESET;
    end else if (chain_shift && !last_clock) begin
      count_reg <= count_reg + 1'b1;
    end
  end

  // ----------------------------------------
  // Shift chain
  // ----------------------------------------
  // Stage k takes clock k+1; the start stage lives in the state machine,
  // so the clear never swallows a start bit
  genvar si;
  generate
    for (si = 0; si < DATA_BITS; si++) begin : g_chain
      always_ff @(posedge core_clk) begin
        if (!rst_n) begin
          shift_reg[si] <= 1'b0;
        end else if (chain_clear) begin
          shift_reg[si] <= 1'b0;
        end else if (chain_shift && count_reg == SLD_CNT_W'(si + 1)) begin
          shift_reg[si] <= s_data;
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Transfer FIFO
  // ----------------------------------------
  logic frm_valid;
  logic [DATA_BITS-1:0] frm_data;

  sld_fifo #(
    .WIDTH(DATA_BITS),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .in_valid(load_pulse),
    .in_ready(fifo_ready),
    .in_data(frm_in),
    .out_valid(frm_valid),
    .out_ready(1'b1),
    .out_data(frm_data)
  );

  // ----------------------------------------
  // Output latches
  // ----------------------------------------
  // Only bits that differ change; equal bits keep their flop value
  genvar gi;
  generate
    for (gi = 0; gi < DATA_BITS; gi++) begin : g_latch
      always_ff @(posedge core_clk) begin
        if (!rst_n) begin
          seg_on[gi] <= SLD_LATCH_RESET[gi];
        end else if (REDUCED && gi == DATA_BITS - 1) begin
          seg_on[gi] <= 1'b0;
        end else if (frm_valid && frm_data[gi] != seg_on[gi]) begin
          seg_on[gi] <= frm_data[gi];
        end
      end
    end
  endgenerate

endmodule : sld_driver

//--- dv/sld_driver_sva.sv
// Port checker for sld_driver.
// Assumes ser_clk runs far slower than core_clk.
`timescale 1ns/100ps
module sld_chk #(
  parameter int DATA_BITS = 35
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ser_clk,
  input wire logic frame_stall,
  input wire logic [DATA_BITS-1:0] seg_on
);
  logic clk_reg;
  logic [DATA_BITS-1:0] seg_reg;
  logic [5:0] rise_reg;
  logic [3:0] since_reg;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  always_ff @(posedge core_clk) begin
    clk_reg <= ser_clk;
    seg_reg <= seg_on;
  end
  // Saturating, so long idle spans never wrap
  always_ff @(posedge core_clk) begin
    if (!rst_n || seg_on != seg_reg) rise_reg <= 6'h00;
    else if (ser_clk && !clk_reg && rise_reg != 6'h3f) rise_reg <= rise_reg + 6'h01;
  end
  always_ff @(posedge core_clk) begin
    if (!rst_n) since_reg <= 4'hf;
    else if (ser_clk && !clk_reg) since_reg <= 4'h0;
    else if (since_reg != 4'hf) since_reg <= since_reg + 4'h1;
  end
  a_reset_clear: assert property (disable iff (1'b0) !rst_n |=> seg_on == '0)
    else $error("seg_on kept in reset");
  a_release_quiet: assert property ($rose(rst_n) |-> (seg_on == '0) [*8])
    else $error("seg_on moved after reset");
  a_change_late: assert property ($changed(seg_on) |-> since_reg >= 4'h3)
    else $error("seg_on too early");
  a_change_soon: assert property ($changed(seg_on) |-> since_reg <= 4'h8)
    else $error("seg_on off clock");
  a_full_frame: assert property ($changed(seg_on) |-> rise_reg >= 6'h24)
    else $error("seg_on short frame");
  a_hold_after: assert property ($changed(seg_on) |=> $stable(seg_on) [*8])
    else $error("seg_on glitch");
  a_idle_hold: assert property ($stable(ser_clk) [*8] |-> $stable(seg_on))
    else $error("seg_on idle move");
  a_no_stall: assert property (!frame_stall)
    else $error("frame_stall high");
  c_load: cover property ($changed(seg_on));
  c_release: cover property ($rose(rst_n));
  c_rise: cover property (ser_clk && !clk_reg);
endmodule : sld_chk
bind sld_driver sld_chk #(.DATA_BITS(DATA_BITS)) i_chk (.core_clk, .rst_n, .ser_clk,
  .frame_stall, .seg_on);

//--- dv/sld_host.sv
// Host model shifting frames into the driver.
// Assumes the bench calls shift after reset.
`timescale 1ns/100ps
module sld_host (
  input wire logic core_clk,
  output logic ser_clk,
  output logic ser_data,
  output logic data_enable
);
  initial begin
    ser_clk = 1'b0;
    ser_data = 1'b1;
    data_enable = 1'b1;
  end
  // Bits lsb first; clock plus data only, 200 ns period
  task automatic shift(input logic [35:0] bits, input int n);
    @(posedge core_clk) #2;
    for (int i = 0; i < n; i++) begin
      ser_data = bits[i];
      repeat (4) @(posedge core_clk);
      #2 ser_clk = 1'b1;
      repeat (4) @(posedge core_clk);
      #2 ser_clk = 1'b0;
    end
    // Released data line floats, so show the inverse
    ser_data = ~ser_data;
  endtask : shift
  task automatic set_enable(input logic en);
    @(posedge core_clk) #2;
    data_enable = en;
  endtask : set_enable
endmodule : sld_host

//--- dv/tb_top.sv
// Bench for sld_driver with host model.
// Assumes the checker binds itself.
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin mismatches++; \
  $display("BAD %s exp %h got %h", nm, ex, got); end end
module tb_top;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic ser_clk, ser_data, data_enable, frame_stall;
  logic [34:0] seg_on;
  logic [34:0] seg_red;
  int mismatches = 0;
  int samples_checked = 0;
  always #12.5 core_clk = ~core_clk;
  sld_host i_host (.core_clk, .ser_clk, .ser_data, .data_enable);
  sld_driver #(.REDUCED(1'b0)) i_dut (.core_clk, .rst_n, .ser_clk, .ser_data,
    .data_enable, .seg_on, .frame_stall);
  // Reduced variant shares the link; its enable comes from the host
  sld_driver #(.REDUCED(1'b1)) i_dut_red (.core_clk, .rst_n, .ser_clk, .ser_data,
    .data_enable, .seg_on(seg_red), .frame_stall());
  // ------------------------------
  // Scenarios
  // ------------------------------
  task automatic end_sim();
    $display("Checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_sim
  task automatic do_reset();
    @(posedge core_clk) #2 rst_n = 1'b0;
    repeat (10) @(posedge core_clk);
    #2 rst_n = 1'b1;
    repeat (4) @(posedge core_clk);
    `CHK("reset", 35'h0, seg_on)
  endtask : do_reset
  task automatic send(input logic [34:0] d);
    i_host.shift({d, 1'b1}, 36);
    repeat (8) @(posedge core_clk);
    `CHK("frame", d, seg_on)
    `CHK("reduced", d & 35'h3_ffff_ffff, seg_red)
    `CHK("stall", 1'b0, frame_stall)
  endtask : send
  task automatic t_reduced();
    // Frame sent with enable low reaches only the full variant
    i_host.set_enable(1'b0);
    i_host.shift({35'h4_0000_0001, 1'b1}, 36);
    repeat (8) @(posedge core_clk);
    `CHK("enable off", 35'h4_0000_0001, seg_on)
    `CHK("reduced off", 35'h3_ffff_ffff, seg_red)
    i_host.set_enable(1'b1);
    send(35'h5_5555_5555);
  endtask : t_reduced
  task automatic t_back();
    i_host.shift({35'h2_aaaa_aaaa, 1'b1}, 36);
    i_host.shift({35'h0_0f0f_0f0f, 1'b1}, 36);
    // Clock held still for a long span
    repeat (400) @(posedge core_clk);
    `CHK("back", 35'h0_0f0f_0f0f, seg_on)
  endtask : t_back
  task automatic t_short();
    i_host.shift({35'h1_2345_6789, 1'b1}, 20);
    repeat (40) @(posedge core_clk);
    `CHK("short", 35'h0_0f0f_0f0f, seg_on)
    i_host.shift({35'h1_2345_6789, 1'b1} >> 20, 16);
    repeat (8) @(posedge core_clk);
    `CHK("rest", 35'h1_2345_6789, seg_on)
  endtask : t_short
  task automatic t_mid_reset();
    i_host.shift({35'h3_0000_0001, 1'b1}, 30);
    do_reset();
    send(35'h0_0000_0180);
  endtask : t_mid_reset
  initial begin
    do_reset();
    send(35'h0_0000_0001);
    send(35'h4_0000_0000);
    send(35'h5_5555_5555);
    send(35'h7_ffff_ffff);
    t_reduced();
    t_back();
    t_short();
    t_mid_reset();
    end_sim();
  end
  initial begin
    #500000;
    mismatches++;
    end_sim();
  end
endmodule : tb_top
